/* File: core/tmr_pkg.sv */
`default_nettype none
package tmr_pkg;
  localparam int ADDR_W = 12;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CFG = 12'h000;
  localparam logic [11:0] OFF_MODE = 12'h004;
  localparam logic [11:0] OFF_CTL = 12'h00c;
  localparam logic [11:0] OFF_IMR = 12'h018;
  localparam logic [11:0] OFF_RIS = 12'h01c;
  localparam logic [11:0] OFF_MIS = 12'h020;
  localparam logic [11:0] OFF_ICR = 12'h024;
  localparam logic [11:0] OFF_ILR = 12'h028;
  localparam logic [11:0] OFF_MATCH = 12'h030;
  localparam logic [11:0] OFF_PRE = 12'h038;
  localparam logic [11:0] OFF_TVAL = 12'h048;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_EN = 0;
  localparam int CTL_EVT_LO = 2;
  localparam int CTL_RTC_DEBUG_RUN_BIT = 4;
  localparam int CTL_TRIG = 5;
  localparam int CTL_INV = 6;
  localparam int MODE_CMR = 2;
  localparam int MODE_AMS = 3;
  localparam int FLG_TO = 0;
  localparam int FLG_CM = 1;
  localparam int FLG_CE = 2;
  localparam int FLG_RTC = 3;
  localparam int FLG_W = 4;
  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] CFG_32 = 3'h0;
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [1:0] MD_ONESHOT = 2'h1;
  localparam logic [1:0] MD_PERIODIC = 2'h2;
  localparam logic [1:0] MD_CAPTURE = 2'h3;
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;
  localparam logic [31:0] RST_ILR = 32'hffffffff;
  localparam logic [31:0] RST_MATCH = 32'hffffffff;
  localparam logic [31:0] MASK_16 = 32'h0000ffff;
  localparam logic [31:0] MASK_32 = 32'hffffffff;
  localparam logic [31:0] RTC_FIRST = 32'h00000001;
  localparam logic [31:0] RTC_ROLL = 32'h00000000;
  localparam int RTC_DIV = 32768;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tmr_bus_req_t;
endpackage
`default_nettype wire

/* File: core/tmr_core.sv */
// Design decisions made here: the plain strobed port and the placing of the registers.
`default_nettype none
module tmr_core #(
  parameter int RTC_DIVIDE = tmr_pkg::RTC_DIV
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire tmr_pkg::tmr_bus_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic ccp_i,
  output logic ccp_o,
  output logic ccp_oe,
  output logic trig_o
);
  import tmr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0] cfg_q;
  logic [3:0] mode_q;
  logic [6:0] ctl_q;
  logic [FLG_W-1:0] imr_q, ris_q;
  logic [31:0] ilr_q, match_q, cnt_q;
  logic [7:0] pre_q, ps_q;
  logic [15:0] cap_q;
  logic [15:0] div_q;
  logic ilr_pend_q, pwm_lvl_q, pwm_q, trig_q;
  logic [31:0] rdata_q;
  logic s1_q, s2_q, s3_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire wr_cfg = bus_req.wr && bus_req.addr == OFF_CFG;
  wire wr_mode = bus_req.wr && bus_req.addr == OFF_MODE;
  wire wr_ctl = bus_req.wr && bus_req.addr == OFF_CTL;
  wire wr_imr = bus_req.wr && bus_req.addr == OFF_IMR;
  wire wr_icr = bus_req.wr && bus_req.addr == OFF_ICR;
  wire wr_ilr = bus_req.wr && bus_req.addr == OFF_ILR;
  wire wr_match = bus_req.wr && bus_req.addr == OFF_MATCH;
  wire wr_pre = bus_req.wr && bus_req.addr == OFF_PRE;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire en = ctl_q[CTL_EN];
  wire inv = ctl_q[CTL_INV];
  wire [1:0] evt = ctl_q[CTL_EVT_LO+1:CTL_EVT_LO];
  wire [1:0] md = mode_q[1:0];
  wire cmr = mode_q[MODE_CMR];
  wire ams = mode_q[MODE_AMS];
  wire is_16 = cfg_q[2];
  wire is_32 = cfg_q == CFG_32;
  wire is_rtc = cfg_q == CFG_RTC;
  wire pwm_m = is_16 && ams && !cmr && md == MD_PERIODIC;
  wire etime_m = is_16 && cmr && md == MD_CAPTURE;
  wire ecnt_m = is_16 && !ams && !cmr && md == MD_CAPTURE;
  wire tmr_m = (is_32 || (is_16 && !ams)) && (md == MD_ONESHOT || md == MD_PERIODIC);
  wire oneshot = md == MD_ONESHOT;
  wire down_m = tmr_m || pwm_m || etime_m;
  wire [31:0] msk = is_16 ? MASK_16 : MASK_32;
  wire [31:0] ilr_m = ilr_q & msk;
  wire [31:0] match_m = match_q & msk;
  wire use_pre = is_16 && (tmr_m || pwm_m);

  // ---------------------------------------------------------------
  // pin synchroniser and edge select
  // ---------------------------------------------------------------
  // s1 only feeds s2, so a metastable sample never reaches the decode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= ccp_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire rise = s2_q && !s3_q;
  wire fall = !s2_q && s3_q;
  wire sel_edge = (evt == EV_RISE) ? rise :
                  (evt == EV_FALL) ? fall :
                  (evt == EV_BOTH) ? (rise || fall) : 1'b0;

  // ---------------------------------------------------------------
  // rtc one second divider
  // ---------------------------------------------------------------
  wire div_end = div_q == 16'(RTC_DIVIDE - 1);
  wire sec_tick = is_rtc && en && rise && div_end;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 16'h0000;
    end else if (!(is_rtc && en)) begin
      div_q <= 16'h0000;
    end else if (rise) begin
      div_q <= div_end ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // prescaler and count enable
  // ---------------------------------------------------------------
  wire ps_zero = ps_q == 8'h00;
  wire tick = use_pre ? ps_zero : 1'b1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ps_q <= 8'h00;
    end else if (!en || !use_pre || ilr_pend_q) begin
      ps_q <= pre_q;
    end else begin
      ps_q <= ps_zero ? pre_q : ps_q - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  wire start = wr_ctl && bus_req.wdata[CTL_EN] && !en;
  wire cnt_zero = cnt_q == 32'h00000000;
  wire [31:0] cnt_dec = cnt_q - 32'h00000001;
  wire timeout = en && tmr_m && tick && cnt_zero && !ilr_pend_q;
  wire ec_hit = en && ecnt_m && sel_edge && (cnt_dec & msk) == match_m;
  wire cap_ev = en && etime_m && sel_edge;
  wire rtc_hit = sec_tick && cnt_q == match_q;
  logic [31:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = is_rtc ? RTC_FIRST : ilr_m;
    end else if (en) begin
      if (ilr_pend_q && down_m) begin
        cnt_d = ilr_m;
      end else if (is_rtc) begin
        if (sec_tick) begin
          cnt_d = rtc_hit ? RTC_ROLL : cnt_q + 32'h00000001;
        end
      end else if (ecnt_m) begin
        if (sel_edge) begin
          cnt_d = ec_hit ? ilr_m : (cnt_dec & msk);
        end
      end else if (down_m && tick) begin
        cnt_d = cnt_zero ? ilr_m : cnt_dec;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= RST_ILR;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // capture register
  // ---------------------------------------------------------------
  // held between edges, so a late read still sees the last event time
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cap_q <= 16'hffff;
    end else if (cap_ev) begin
      cap_q <= cnt_q[15:0];
    end
  end

  // ---------------------------------------------------------------
  // pwm and trigger outputs
  // ---------------------------------------------------------------
  wire pwm_lvl_d = !pwm_m ? 1'b0 :
                   (cnt_q == ilr_m) ? 1'b1 :
                   (cnt_q == match_m) ? 1'b0 : pwm_lvl_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwm_lvl_q <= 1'b0;
      pwm_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      pwm_lvl_q <= pwm_lvl_d;
      pwm_q <= pwm_m && (pwm_lvl_d ^ inv);
      trig_q <= timeout && ctl_q[CTL_TRIG];
    end
  end

  assign ccp_o = pwm_q;
  assign ccp_oe = pwm_m;
  assign trig_o = trig_q;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  wire hw_stop = (timeout && oneshot) || ec_hit;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= 3'h0;
      mode_q <= 4'h0;
      ctl_q <= 7'h00;
      imr_q <= 4'h0;
      ilr_q <= RST_ILR;
      match_q <= RST_MATCH;
      pre_q <= 8'h00;
      ilr_pend_q <= 1'b0;
    end else begin
      if (wr_cfg) cfg_q <= bus_req.wdata[2:0];
      if (wr_mode) mode_q <= bus_req.wdata[3:0];
      if (wr_ctl) begin
        ctl_q <= bus_req.wdata[6:0];
      end else if (hw_stop) begin
        ctl_q[CTL_EN] <= 1'b0;
      end
      if (wr_imr) imr_q <= bus_req.wdata[FLG_W-1:0];
      if (wr_ilr) ilr_q <= bus_req.wdata;
      if (wr_match) match_q <= bus_req.wdata;
      if (wr_pre) pre_q <= bus_req.wdata[7:0];
      ilr_pend_q <= wr_ilr && en && !wr_ctl;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // a set in the same cycle as its clear wins, so no event is lost
  logic [FLG_W-1:0] flg_set;
  always_comb begin
    flg_set = '0;
    flg_set[FLG_TO] = timeout;
    flg_set[FLG_CM] = ec_hit;
    flg_set[FLG_CE] = cap_ev;
    flg_set[FLG_RTC] = rtc_hit;
  end
  wire [FLG_W-1:0] flg_clr = wr_icr ? bus_req.wdata[FLG_W-1:0] : '0;
  wire [FLG_W-1:0] mis = ris_q & imr_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ris_q <= '0;
    end else begin
      ris_q <= (ris_q & ~flg_clr) | flg_set;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  wire [31:0] tval = etime_m ? {16'h0000, cap_q} : cnt_q;
  logic [31:0] rd_mux;
  always_comb begin
    case (bus_req.addr)
      OFF_CFG: rd_mux = {29'h0, cfg_q};
      OFF_MODE: rd_mux = {28'h0, mode_q};
      OFF_CTL: rd_mux = {25'h0, ctl_q};
      OFF_IMR: rd_mux = {28'h0, imr_q};
      OFF_RIS: rd_mux = {28'h0, ris_q};
      OFF_MIS: rd_mux = {28'h0, mis};
      OFF_ILR: rd_mux = ilr_m;
      OFF_MATCH: rd_mux = match_m;
      OFF_PRE: rd_mux = {24'h0, pre_q};
      OFF_TVAL: rd_mux = tval;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= bus_req.rd ? rd_mux : 32'h00000000;
    end
  end
  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_capture;
    @(posedge clock) disable iff (!arst_n)
      cap_ev |=> cap_q == $past(cnt_q[15:0]) && ris_q[FLG_CE];
  endproperty
  a_capture: assert property (p_capture) else $error("edge capture wrong");

  property p_hold;
    @(posedge clock) disable iff (!arst_n)
      !cap_ev |=> $stable(cap_q);
  endproperty
  a_hold: assert property (p_hold) else $error("capture not held");

  property p_etime_step;
    @(posedge clock) disable iff (!arst_n)
      en && etime_m && !cnt_zero && !ilr_pend_q && !bus_req.wr
        |=> cnt_q == $past(cnt_q) - 32'h00000001;
  endproperty
  a_etime_step: assert property (p_etime_step) else $error("edge time step wrong");

  property p_reload;
    @(posedge clock) disable iff (!arst_n)
      en && down_m && tick && cnt_zero && !ilr_pend_q && !bus_req.wr
        |=> cnt_q == $past(ilr_m);
  endproperty
  a_reload: assert property (p_reload) else $error("reload at zero wrong");

  property p_ilr_apply;
    @(posedge clock) disable iff (!arst_n)
      wr_ilr && en && down_m ##1 !bus_req.wr |=> cnt_q == $past(ilr_m);
  endproperty
  a_ilr_apply: assert property (p_ilr_apply) else $error("load not applied");

  property p_pwm_quiet;
    @(posedge clock) disable iff (!arst_n)
      pwm_m && !bus_req.wr |=> (ris_q & ~$past(ris_q)) == '0;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("flag set in pwm");

  property p_pwm_on;
    @(posedge clock) disable iff (!arst_n)
      pwm_m && cnt_q == ilr_m |=> pwm_q == !$past(inv);
  endproperty
  a_pwm_on: assert property (p_pwm_on) else $error("pwm not active at load");

  property p_pwm_off;
    @(posedge clock) disable iff (!arst_n)
      pwm_m && cnt_q == match_m && cnt_q != ilr_m |=> pwm_q == $past(inv);
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm not off at match");

  property p_clear;
    @(posedge clock) disable iff (!arst_n)
      wr_icr && bus_req.wdata[FLG_TO] && !timeout |=> !ris_q[FLG_TO];
  endproperty
  a_clear: assert property (p_clear) else $error("timeout flag not cleared");

  property p_oneshot;
    @(posedge clock) disable iff (!arst_n)
      timeout && oneshot && !wr_ctl |=> !en;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");

  property p_rtc;
    @(posedge clock) disable iff (!arst_n)
      rtc_hit && !bus_req.wr |=> cnt_q == RTC_ROLL && en && ris_q[FLG_RTC];
  endproperty
  a_rtc: assert property (p_rtc) else $error("rtc match wrong");

  property p_ecnt_stop;
    @(posedge clock) disable iff (!arst_n)
      ec_hit && !wr_ctl |=> !en && cnt_q == $past(ilr_m) ##1 !en;
  endproperty
  a_ecnt_stop: assert property (p_ecnt_stop) else $error("edge count not stopped");

  property p_sync;
    @(posedge clock) disable iff (!arst_n)
      $rose(s2_q) |-> $past(ccp_i, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin not synchronised");

  c_capture: cover property (@(posedge clock) disable iff (!arst_n) cap_ev);
  c_pwm: cover property (@(posedge clock) disable iff (!arst_n) pwm_m && $rose(pwm_q));
  c_rtc: cover property (@(posedge clock) disable iff (!arst_n) rtc_hit);
  c_ecnt: cover property (@(posedge clock) disable iff (!arst_n) ec_hit);
endmodule
`default_nettype wire

/* File: tb/tmr_pin_model.sv */
`default_nettype none
module tmr_pin_model (
  input wire logic clock,
  input wire logic rtc_run,
  input wire logic lvl_req,
  output logic ext
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // slow pin clock, stands still outside its frame
  // ------------------------------------------------------------
  logic [3:0] div_q = 4'h0;
  logic osc_q = 1'b0;
  always @(posedge clock) begin
    if (rtc_run) begin
      div_q <= div_q + 4'h1;
      if (div_q == 4'hf) osc_q <= ~osc_q;
    end
  end
  // every level lasts far beyond the two-cycle minimum of the synchroniser
  assign ext = rtc_run ? osc_q : lvl_req;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
module testbench import tmr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  tmr_bus_req_t bus_req = '0;
  logic [31:0] rdata, d, c1, c2;
  logic ccp_o, ccp_oe, trig_o, ext;
  logic rtc_run = 1'b0;
  logic lvl = 1'b0;
  wire logic pin;
  int err_total = 0, compares = 0, trigs = 0, tick = 0, t1, t2, k, m, hi, s, over;
  logic [1:0] evs [3] = '{EV_RISE, EV_FALL, EV_BOTH};

  always #10 clock = ~clock;
  always @(posedge clock) begin
    tick <= tick + 1;
    if (trig_o === 1'b1) trigs++;
  end

  tmr_core #(.RTC_DIVIDE(4)) u_tmr_core (.clock(clock), .arst_n(arst_n), .bus_req(bus_req),
    .rdata(rdata), .ccp_i(pin), .ccp_o(ccp_o), .ccp_oe(ccp_oe), .trig_o(trig_o));
  tmr_pin_model u_tmr_pin_model (.clock(clock), .rtc_run(rtc_run), .lvl_req(lvl), .ext(ext));
  // pwm drives the pin itself, otherwise the far side does
  assign pin = ccp_oe ? ccp_o : ext;

  // ------------------------------------------------------------
  // bus, pin and checking helpers
  // ------------------------------------------------------------
  task automatic final_report;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pin_to(input logic v, output int t);
    @(posedge clock);
    lvl <= v;
    t = tick;
    repeat (6) @(posedge clock);
  endtask
  task automatic poll(input int b, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      rd(OFF_RIS, d);
      if (d[b] === 1'b1) break;
    end
    if (i == lim) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic restart(input logic [31:0] cfg, input logic [31:0] mode);
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'hf);
    wr(OFF_CFG, cfg);
    wr(OFF_MODE, mode);
  endtask
  function automatic int pwm_high(int ld, int mt, bit inv, int win);
    int h;
    h = inv ? (ld + 1) - (ld - mt) : ld - mt;
    return (win / (ld + 1)) * h;
  endfunction

  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    final_report();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h3fa36684));
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    rd(OFF_ILR, d); chk("ilr_rst", d, RST_ILR);
    rd(OFF_MATCH, d); chk("match_rst", d, RST_MATCH);
    rd(12'h100, d); chk("unmapped", d, 32'h0);
    // edge time: spacing of two captures equals clock cycles, prescaler ignored
    restart(32'h4, 32'h7);
    wr(OFF_PRE, 32'h5);
    wr(OFF_IMR, 32'h4);
    wr(OFF_ILR, MASK_16);
    wr(OFF_CTL, 32'h1);
    pin_to(1'b1, t1);
    rd(OFF_TVAL, c1); chk("cap_hi", c1 & ~MASK_16, 32'h0);
    rd(OFF_RIS, d); chk("ris_cap", 32'(d[FLG_CE]), 32'h1);
    rd(OFF_MIS, d); chk("mis_cap", 32'(d[FLG_CE]), 32'h1);
    pin_to(1'b0, k);
    k = 20 + $urandom % 40;
    repeat (k) @(posedge clock);
    rd(OFF_TVAL, d); chk("cap_held", d, c1);
    pin_to(1'b1, t2);
    rd(OFF_TVAL, c2); chk("cap_delta", c1 - c2, 32'(t2 - t1));
    pin_to(1'b0, k);
    foreach (evs[i]) begin
      wr(OFF_CTL, 32'h0);
      wr(OFF_ICR, 32'h4);
      wr(OFF_CTL, {28'h0, evs[i], 2'b01});
      pin_to(1'b1, k);
      rd(OFF_RIS, d); chk("rise_cap", 32'(d[FLG_CE]), 32'(evs[i] != EV_FALL));
      wr(OFF_ICR, 32'h4);
      pin_to(1'b0, k);
      rd(OFF_RIS, d); chk("fall_cap", 32'(d[FLG_CE]), 32'(evs[i] != EV_RISE));
    end
    wr(OFF_ILR, 32'h80);
    repeat (300) @(posedge clock);
    pin_to(1'b1, k);
    rd(OFF_TVAL, d); chk("cap_reload", 32'(d <= 32'h80), 32'h1);
    pin_to(1'b0, k);
    // pwm with random match, both polarities, then a live period change
    restart(32'h4, 32'ha);
    wr(OFF_PRE, 32'h0);
    wr(OFF_ILR, 32'h9);
    m = 1 + $urandom % 8;
    wr(OFF_MATCH, 32'(m));
    for (int inv = 0; inv < 2; inv++) begin
      wr(OFF_CTL, 32'h0);
      wr(OFF_CTL, 32'h1 | 32'(inv << CTL_INV));
      chk("pwm_oe", 32'(ccp_oe), 32'h1);
      repeat (25) @(posedge clock);
      hi = 0;
      repeat (40) @(posedge clock) if (ccp_o === 1'b1) hi++;
      chk("pwm_high", 32'(hi), 32'(pwm_high(9, m, inv[0], 40)));
    end
    wr(OFF_CTL, 32'h1);
    wr(OFF_ILR, 32'd19);
    repeat (45) @(posedge clock);
    hi = 0;
    repeat (80) @(posedge clock) if (ccp_o === 1'b1) hi++;
    chk("pwm_period", 32'(hi), 32'(pwm_high(19, m, 1'b0, 80)));
    rd(OFF_RIS, d); chk("pwm_flags", d, 32'h0);
    // one-shot in 32-bit and paired 16-bit configurations
    for (int i = 0; i < 2; i++) begin
      restart(i ? 32'h4 : 32'(CFG_32), 32'(MD_ONESHOT));
      wr(OFF_IMR, 32'h1);
      k = 10 + $urandom % 30;
      wr(OFF_ILR, i ? 32'h10000 | 32'(k) : 32'(k));
      trigs = 0;
      wr(OFF_CTL, 32'h21);
      poll(FLG_TO, 60);
      repeat (4) @(posedge clock);
      rd(OFF_CTL, d); chk("oneshot_stop", 32'(d[CTL_EN]), 32'h0);
      chk("oneshot_trig", 32'(trigs), 32'h1);
      wr(OFF_ICR, 32'h0);
      rd(OFF_RIS, d); chk("icr_zero", 32'(d[FLG_TO]), 32'h1);
      wr(OFF_ICR, 32'h1);
      rd(OFF_RIS, d); chk("icr_one", 32'(d[FLG_TO]), 32'h0);
      rd(OFF_MIS, d); chk("icr_mis", 32'(d[FLG_TO]), 32'h0);
    end
    restart(32'(CFG_32), 32'(MD_PERIODIC));
    wr(OFF_ILR, 32'd15);
    trigs = 0;
    wr(OFF_CTL, 32'h21);
    repeat (68) @(posedge clock);
    rd(OFF_CTL, d); chk("periodic_run", 32'(d[CTL_EN]), 32'h1);
    chk("periodic_trigs", 32'(trigs >= 3), 32'h1);
    // rtc: count walks 1, 2, back to 0 and on, flag never cleared
    restart(32'(CFG_RTC), 32'h0);
    wr(OFF_MATCH, 32'h2);
    wr(OFF_IMR, 32'h8);
    rtc_run <= 1'b1;
    wr(OFF_CTL, 32'h1);
    s = 0;
    over = 0;
    repeat (320) begin
      rd(OFF_TVAL, d);
      if (d > 32'h2) over++;
      if (s == 0 && d == 32'h2) s = 1;
      if (s == 1 && d == 32'h0) s = 2;
      if (s == 2 && d == 32'h1) s = 3;
    end
    chk("rtc_walk", 32'(s), 32'h3);
    chk("rtc_bound", 32'(over), 32'h0);
    rd(OFF_RIS, d); chk("rtc_flag", 32'(d[FLG_RTC]), 32'h1);
    wr(OFF_CTL, 32'h0);
    rtc_run <= 1'b0;
    // edge count: load 10, match 6, stops on the fourth edge
    restart(32'h4, 32'h3);
    wr(OFF_ILR, 32'd10);
    wr(OFF_MATCH, 32'd6);
    wr(OFF_CTL, 32'h1);
    for (int j = 0; j < 4; j++) begin
      if (j == 3) begin
        rd(OFF_RIS, d); chk("cnt_early", 32'(d[FLG_CM]), 32'h0);
      end
      pin_to(1'b1, k);
      pin_to(1'b0, k);
    end
    rd(OFF_RIS, d); chk("cnt_flag", 32'(d[FLG_CM]), 32'h1);
    rd(OFF_CTL, d); chk("cnt_stop", 32'(d[CTL_EN]), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
